// file: src/sysconf_pkg.sv
// Constants for the system configuration register bank
`default_nettype none
package sysconf_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_REMAP      = 8'h00;
  localparam logic [7:0] OFS_PERIPH     = 8'h04;
  localparam logic [7:0] OFS_IRQ_0_3    = 8'h08;
  localparam logic [7:0] OFS_IRQ_4_7    = 8'h0C;
  localparam logic [7:0] OFS_IRQ_8_11   = 8'h10;
  localparam logic [7:0] OFS_IRQ_12_15  = 8'h14;
  localparam logic [7:0] OFS_COMP       = 8'h20;

  // Field positions
  localparam int         PHY_SEL_BIT    = 23;
  localparam int         COMP_EN_BIT    = 0;
  localparam int         COMP_RDY_BIT   = 8;
  localparam int         NIBBLE_W       = 4;
  localparam int         LINES_PER_REG  = 4;
  localparam int         IRQ_LINES      = 16;

  // Reset values
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;

  // Port select codes
  localparam logic [3:0] PORT_A_CODE    = 4'h0;
  localparam logic [3:0] PORT_LAST_CODE = 4'h8;

  // Compensation cell settle time, counted in cycles
  localparam int          COMP_SETTLE_CYC = 16;

  // Memory seen at address zero
  typedef enum logic [1:0] {
    MAP_MAIN_FLASH = 2'b00,
    MAP_SYS_FLASH  = 2'b01,
    MAP_SMC_BANK1  = 2'b10,
    MAP_SRAM1      = 2'b11
  } remap_t;

endpackage : sysconf_pkg
`default_nettype wire

// file: src/sysconf_sync.sv
// Three-stage synchroniser with agreement on the last two stages
`timescale 1ns/100ps
`default_nettype none
module sysconf_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Shift chain; output follows only when stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule : sysconf_sync
`default_nettype wire

// file: src/system_config_regs.sv
// APB register bank for memory remap, PHY select and interrupt routing
`timescale 1ns/100ps
`default_nettype none
module system_config_regs #(
  parameter int COMP_SETTLE = sysconf_pkg::COMP_SETTLE_CYC
) (
  input  wire logic                MCLK,
  input  wire logic                RESET_N,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  input  wire logic [3:0]          PSTRB,
  output var  logic [31:0]         PRDATA,
  output var  logic                PREADY,
  output var  logic                PSLVERR,
  input  wire logic [1:0]          BOOT_SEL,
  output var  sysconf_pkg::remap_t REMAP_SEL,
  output var  logic                PHY_RMII,
  output var  logic [63:0]         IRQ_SRC_SEL,
  output var  logic [15:0]         IRQ_LINE_VALID,
  output var  logic                COMP_ENABLE,
  input  wire logic                COMP_READY_IN
);
  import sysconf_pkg::*;

  // Refuse a settle count the 16-bit counter cannot hold
  if (COMP_SETTLE < 1 || COMP_SETTLE > 65535) begin : g_bad_settle
    $error("COMP_SETTLE out of range");
  end

  logic [1:0]  boot_sync;
  logic        comp_rdy_sync;
  logic        boot_loaded_q;
  logic [63:0] irq_sel_q;
  logic [15:0] settle_cnt_q;
  logic        comp_rdy_q;
  logic        access;
  logic        wr;
  logic        rd;
  logic        hit;
  logic [31:0] rdata_d;

  // Boot pins and analog ready flag come from outside the clock domain
  sysconf_sync #(.W(2)) u_boot_sync (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .din   (BOOT_SEL),
    .dout  (boot_sync)
  );

  sysconf_sync #(.W(1)) u_rdy_sync (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .din   (COMP_READY_IN),
    .dout  (comp_rdy_sync)
  );

  // Merge byte lanes of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Valid when the port code exists for this line
  function automatic logic code_ok(input logic [3:0] code, input int line);
    if (line >= 12) begin
      return code < PORT_LAST_CODE;
    end
    return code <= PORT_LAST_CODE;
  endfunction : code_ok

  // APB decode; slave answers in the access cycle with no wait
  assign access = PSEL && PENABLE;
  assign wr     = access && PWRITE;
  assign rd     = access && !PWRITE;
  always_comb begin
    case (PADDR)
      OFS_REMAP, OFS_PERIPH, OFS_IRQ_0_3, OFS_IRQ_4_7,
      OFS_IRQ_8_11, OFS_IRQ_12_15, OFS_COMP: hit = 1'b1;
      default:                               hit = 1'b0;
    endcase
  end

  // Remap field: follows boot pins after reset until the first software write with lane 0 strobed, which overrides
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REMAP_SEL     <= MAP_MAIN_FLASH;
      boot_loaded_q <= 1'b0;
    end else if (wr && PADDR == OFS_REMAP && PSTRB[0]) begin
      REMAP_SEL     <= remap_t'(PWDATA[1:0]);
      boot_loaded_q <= 1'b1;
    end else if (!boot_loaded_q) begin
      REMAP_SEL     <= remap_t'(boot_sync);
    end
  end

  // Boot value settles once the synchroniser has filled
  logic [1:0] boot_wait_q;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      boot_wait_q <= 2'd0;
    end else if (boot_wait_q != 2'd3) begin
      boot_wait_q <= boot_wait_q + 2'd1;
    end
  end

  // PHY select bit
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PHY_RMII <= 1'b0;
    end else if (wr && PADDR == OFS_PERIPH && PSTRB[2]) begin
      PHY_RMII <= PWDATA[PHY_SEL_BIT];
    end
  end

  // Interrupt source nibbles, four lines per register
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_sel_q <= '0;
    end else if (wr) begin
      for (int r = 0; r < 4; r++) begin
        if (PADDR == OFS_IRQ_0_3 + 8'(r * 4)) begin
          irq_sel_q[r*16 +: 16] <= 16'(merge({16'h0000, irq_sel_q[r*16 +: 16]},
                                             PWDATA, PSTRB));
        end
      end
    end
  end

  // Routing outputs with validity per line
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ_SRC_SEL    <= '0;
      IRQ_LINE_VALID <= '1;
    end else begin
      IRQ_SRC_SEL <= irq_sel_q;
      for (int l = 0; l < IRQ_LINES; l++) begin
        IRQ_LINE_VALID[l] <= code_ok(irq_sel_q[l*4 +: 4], l);
      end
    end
  end

  // Compensation cell enable
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      COMP_ENABLE <= 1'b0;
    end else if (wr && PADDR == OFS_COMP && PSTRB[0]) begin
      COMP_ENABLE <= PWDATA[COMP_EN_BIT];
    end
  end

  // Ready flag after settle time and cell's own ready
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      settle_cnt_q <= '0;
      comp_rdy_q   <= 1'b0;
    end else if (!COMP_ENABLE) begin
      settle_cnt_q <= '0;
      comp_rdy_q   <= 1'b0;
    end else begin
      if (settle_cnt_q != 16'(COMP_SETTLE)) begin
        settle_cnt_q <= settle_cnt_q + 16'd1;
      end
      comp_rdy_q <= (settle_cnt_q == 16'(COMP_SETTLE)) && comp_rdy_sync;
    end
  end

  // Read mux; reserved bits are zero
  always_comb begin
    rdata_d = RST_ZERO;
    case (PADDR)
      OFS_REMAP:     rdata_d[1:0] = REMAP_SEL;
      OFS_PERIPH:    rdata_d[PHY_SEL_BIT] = PHY_RMII;
      OFS_IRQ_0_3:   rdata_d[15:0] = irq_sel_q[15:0];
      OFS_IRQ_4_7:   rdata_d[15:0] = irq_sel_q[31:16];
      OFS_IRQ_8_11:  rdata_d[15:0] = irq_sel_q[47:32];
      OFS_IRQ_12_15: rdata_d[15:0] = irq_sel_q[63:48];
      OFS_COMP: begin
        rdata_d[COMP_EN_BIT]  = COMP_ENABLE;
        rdata_d[COMP_RDY_BIT] = comp_rdy_q;
      end
      default:       rdata_d = RST_ZERO;
    endcase
  end

  // APB answer registered: ready asserted in access phase after setup
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !hit;
      PRDATA  <= (PSEL && !PENABLE && !PWRITE) ? rdata_d : RST_ZERO;
    end
  end

  // Assertions
  property p_remap_write;
    @(posedge MCLK) disable iff (!RESET_N)
      (wr && PREADY && PADDR == OFS_REMAP && PSTRB[0]) |=> (REMAP_SEL == $past(PWDATA[1:0]));
  endproperty
  a_remap_write: assert property (p_remap_write) else $error("remap write lost");

  property p_boot_follow;
    @(posedge MCLK) disable iff (!RESET_N)
      (!boot_loaded_q && !(wr && PADDR == OFS_REMAP)) |=> (REMAP_SEL == $past(boot_sync));
  endproperty
  a_boot_follow: assert property (p_boot_follow) else $error("boot value not loaded");

  property p_phy_write;
    @(posedge MCLK) disable iff (!RESET_N)
      (wr && PADDR == OFS_PERIPH && PSTRB[2]) |=> (PHY_RMII == $past(PWDATA[23]));
  endproperty
  a_phy_write: assert property (p_phy_write) else $error("phy select not stored");

  property p_irq_out;
    @(posedge MCLK) disable iff (!RESET_N)
      1'b1 |=> (IRQ_SRC_SEL == $past(irq_sel_q));
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq routing stale");

  property p_irq0_write;
    @(posedge MCLK) disable iff (!RESET_N)
      (wr && PADDR == OFS_IRQ_0_3 && PSTRB == 4'hF) |=> ##1 (IRQ_SRC_SEL[15:0] == $past(PWDATA[15:0], 2));
  endproperty
  a_irq0_write: assert property (p_irq0_write) else $error("line 0-3 select wrong");

  property p_irq1_write;
    @(posedge MCLK) disable iff (!RESET_N)
      (wr && PADDR == OFS_IRQ_4_7 && PSTRB == 4'hF) |=> ##1 (IRQ_SRC_SEL[31:16] == $past(PWDATA[15:0], 2));
  endproperty
  a_irq1_write: assert property (p_irq1_write) else $error("line 4-7 select wrong");

  property p_line15_code8;
    @(posedge MCLK) disable iff (!RESET_N)
      (irq_sel_q[63:60] == PORT_LAST_CODE) |=> !IRQ_LINE_VALID[15];
  endproperty
  a_line15_code8: assert property (p_line15_code8) else $error("code 8 accepted on line 15");

  property p_reserved_zero;
    @(posedge MCLK) disable iff (!RESET_N)
      (rd && PREADY && PADDR == OFS_PERIPH) |-> (PRDATA[22:0] == 23'h0 && PRDATA[31:24] == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

  property p_unmapped_err;
    @(posedge MCLK) disable iff (!RESET_N)
      (PSEL && !PENABLE && !hit) |=> (PREADY && PSLVERR);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped address not flagged");

  property p_remap_boot_hold;
    @(posedge MCLK) disable iff (!RESET_N)
      (boot_wait_q != 2'd3 && !boot_loaded_q) |-> (REMAP_SEL == MAP_MAIN_FLASH);
  endproperty
  a_remap_boot_hold: assert property (p_remap_boot_hold) else $error("remap left default early");

  property p_remap_keep;
    @(posedge MCLK) disable iff (!RESET_N)
      (wr && PADDR == OFS_REMAP && !PSTRB[0] && boot_loaded_q) |=> $stable(REMAP_SEL);
  endproperty
  a_remap_keep: assert property (p_remap_keep) else $error("remap changed without lane");

  property p_phy_keep;
    @(posedge MCLK) disable iff (!RESET_N)
      (wr && PADDR == OFS_PERIPH && !PSTRB[2]) |=> $stable(PHY_RMII);
  endproperty
  a_phy_keep: assert property (p_phy_keep) else $error("phy select changed without lane");

  property p_irq2_write;
    @(posedge MCLK) disable iff (!RESET_N)
      (wr && PADDR == OFS_IRQ_8_11 && PSTRB == 4'hF) |=> ##1 (IRQ_SRC_SEL[47:32] == $past(PWDATA[15:0], 2));
  endproperty
  a_irq2_write: assert property (p_irq2_write) else $error("line 8-11 select wrong");

  property p_irq3_write;
    @(posedge MCLK) disable iff (!RESET_N)
      (wr && PADDR == OFS_IRQ_12_15 && PSTRB == 4'hF) |=> ##1 (IRQ_SRC_SEL[63:48] == $past(PWDATA[15:0], 2));
  endproperty
  a_irq3_write: assert property (p_irq3_write) else $error("line 12-15 select wrong");

  property p_reserved_code;
    @(posedge MCLK) disable iff (!RESET_N)
      (irq_sel_q[51:48] > PORT_LAST_CODE) |=> !IRQ_LINE_VALID[12];
  endproperty
  a_reserved_code: assert property (p_reserved_code) else $error("reserved port code accepted");

  property p_unmapped_keep;
    @(posedge MCLK) disable iff (!RESET_N)
      (PSEL && PENABLE && PWRITE && !hit) |=> ($stable(irq_sel_q) && $stable(PHY_RMII) && $stable(COMP_ENABLE));
  endproperty
  a_unmapped_keep: assert property (p_unmapped_keep) else $error("unmapped write changed state");

  property p_comp_write;
    @(posedge MCLK) disable iff (!RESET_N)
      (wr && PADDR == OFS_COMP && PSTRB[0]) |=> (COMP_ENABLE == $past(PWDATA[COMP_EN_BIT]));
  endproperty
  a_comp_write: assert property (p_comp_write) else $error("compensation enable not stored");

  property p_ready_pulse;
    @(posedge MCLK) disable iff (!RESET_N)
      PREADY |=> !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

  property p_rdata_idle;
    @(posedge MCLK) disable iff (!RESET_N)
      !PREADY |-> (PRDATA == RST_ZERO);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");

  c_remap_sram: cover property (@(posedge MCLK) REMAP_SEL == MAP_SRAM1);
  c_rmii:       cover property (@(posedge MCLK) PHY_RMII);
  c_port_i:     cover property (@(posedge MCLK) IRQ_SRC_SEL[3:0] == PORT_LAST_CODE);
  c_comp_rdy:   cover property (@(posedge MCLK) comp_rdy_q);
  c_unmapped:   cover property (@(posedge MCLK) PREADY && PSLVERR);
endmodule : system_config_regs
`default_nettype wire

// file: test/system_config_regs_tb.sv
// Self-checking bench for the system configuration register bank
`timescale 1ns/100ps
`default_nettype none
module system_config_regs_tb;
  import sysconf_pkg::*;
  logic        mclk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  boot_sel;
  logic [3:0]  pstrb;
  logic        comp_ready_in;
  remap_t      remap_sel;
  logic        phy_rmii;
  logic [63:0] irq_src_sel;
  logic [15:0] irq_line_valid;
  logic        comp_enable;
  int          miscompares;
  int          n_checks;
  logic [31:0] rd;
  logic        er;

  // 10 MHz system clock
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  // Short settle count keeps the ready flag quick
  system_config_regs #(.COMP_SETTLE(2)) dut (
    .MCLK           (mclk),
    .RESET_N        (reset_n),
    .PSEL           (psel),
    .PENABLE        (penable),
    .PWRITE         (pwrite),
    .PADDR          (paddr),
    .PWDATA         (pwdata),
    .PSTRB          (pstrb),
    .PRDATA         (prdata),
    .PREADY         (pready),
    .PSLVERR        (pslverr),
    .BOOT_SEL       (boot_sel),
    .REMAP_SEL      (remap_sel),
    .PHY_RMII       (phy_rmii),
    .IRQ_SRC_SEL    (irq_src_sel),
    .IRQ_LINE_VALID (irq_line_valid),
    .COMP_ENABLE    (comp_enable),
    .COMP_READY_IN  (comp_ready_in)
  );

  // Verdict and end of run
  task automatic end_of_test;
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Compare seen against expected
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      miscompares++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Read a mapped register and compare, no error expected
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk({er, rd}, {1'b0, exp});
  endtask : rdchk

  // Reset pulse, then let boot pins settle
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask : do_reset

  // Values straight after reset
  task automatic t_reset_values;
    chk(remap_sel, boot_sel);
    rdchk(OFS_REMAP, {30'h0, boot_sel});
    rdchk(OFS_PERIPH, RST_ZERO);
    rdchk(OFS_IRQ_0_3, RST_ZERO);
    rdchk(OFS_IRQ_4_7, RST_ZERO);
    chk(phy_rmii, 1'b0);
    chk(irq_src_sel, 64'h0);
    chk(irq_line_valid, 16'hFFFF);
  endtask : t_reset_values

  // Plain register write
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr32

  // Every remap code, then boot pins must no longer matter
  task automatic t_remap;
    logic [1:0] c;
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      wr32(OFS_REMAP, 32'hFFFF_FFFC | 32'(k));
      rdchk(OFS_REMAP, {30'h0, c});
      chk(remap_sel, c);
    end
    boot_sel <= 2'b01;
    repeat (8) @(posedge mclk);
    chk(remap_sel, 2'b11);
  endtask : t_remap

  // PHY select; the ethernet side is idle here
  task automatic t_phy;
    wr32(OFS_PERIPH, 32'hFFFF_FFFF);
    rdchk(OFS_PERIPH, 32'h0080_0000);
    chk(phy_rmii, 1'b1);
    wr32(OFS_PERIPH, 32'h0);
    rdchk(OFS_PERIPH, RST_ZERO);
    chk(phy_rmii, 1'b0);
  endtask : t_phy

  // All port codes 0..8 plus one reserved code across sixteen lines
  task automatic t_irq;
    logic [15:0] v [4];
    logic [7:0]  a [4];
    v = '{16'h3210, 16'h7654, 16'h5088, 16'h8219};
    a = '{OFS_IRQ_0_3, OFS_IRQ_4_7, OFS_IRQ_8_11, OFS_IRQ_12_15};
    for (int k = 0; k < 4; k++) begin
      wr32(a[k], {16'hFFFF, v[k]});
    end
    for (int k = 0; k < 4; k++) begin
      rdchk(a[k], {16'h0, v[k]});
    end
    chk(irq_src_sel, 64'h8219_5088_7654_3210);
    chk(irq_line_valid, 16'h6FFF);
  endtask : t_irq

  // Lanes with a low strobe keep their old contents
  task automatic t_strobe;
    pstrb <= 4'h2;
    wr32(OFS_IRQ_0_3, 32'hFFFF_54FF);
    wr32(OFS_PERIPH, 32'hFFFF_FFFF);
    wr32(OFS_REMAP, 32'hFFFF_FFFC);
    pstrb <= 4'hF;
    rdchk(OFS_IRQ_0_3, 32'h0000_5410);
    rdchk(OFS_PERIPH, RST_ZERO);
    rdchk(OFS_REMAP, 32'h0000_0003);
  endtask : t_strobe

  // Holes in the map answer with an error and no data
  task automatic t_unmapped;
    apb(1'b1, 8'h18, 32'hFFFF_FFFF);
    chk(er, 1'b1);
    apb(1'b0, 8'h18, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    apb(1'b0, 8'h1C, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
  endtask : t_unmapped

  // Compensation control at the far offset; ready also needs the cell flag
  task automatic t_comp;
    wr32(OFS_COMP, 32'hFFFF_FFFF);
    repeat (10) @(posedge mclk);
    chk(comp_enable, 1'b1);
    rdchk(OFS_COMP, 32'h0000_0001);
    comp_ready_in <= 1'b1;
    repeat (8) @(posedge mclk);
    rdchk(OFS_COMP, 32'h0000_0101);
  endtask : t_comp

  // Main sequence, with a second reset in mid-run
  initial begin
    reset_n     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    boot_sel    = 2'b10;
    pstrb       = 4'hF;
    comp_ready_in = 1'b0;
    miscompares = 0;
    n_checks    = 0;
    do_reset();
    t_reset_values();
    t_remap();
    t_phy();
    t_irq();
    t_strobe();
    t_unmapped();
    t_comp();
    // Leave RMII set so the second reset must clear it
    wr32(OFS_PERIPH, 32'h0080_0000);
    do_reset();
    t_reset_values();
    end_of_test();
  end
endmodule : system_config_regs_tb
`default_nettype wire
